// ---- ssm_pkg.sv ----
// Purpose: Shared constants and types for the SPI port with slave-select modes.
// Assumes: An 8-bit shift register and a system clock at 20 MHz.
// Notes:   Every offset-free control value of the port is named here once.
`default_nettype none

package ssm_pkg;

  // ---------------------------------------------------------------------------
  // Select pin modes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SSM_SEL_THREE_WIRE = 2'h0;  // Three wire, select pin unused.
  localparam logic [1:0] SSM_SEL_MULTI      = 2'h1;  // Select pin is an input.
  localparam int         SSM_SEL_HIGH_POS   = 1;     // High bit: select pin is an output.
  localparam int         SSM_SEL_LOW_POS    = 0;     // Low bit: level driven on the select pin.

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SSM_SEL_RESET      = 2'h1;  // Multi-master, four-wire slave.
  localparam logic       SSM_MASTER_RESET   = 1'h0;
  localparam logic       SSM_ENABLE_RESET   = 1'h0;
  localparam logic [7:0] SSM_BYTE_RESET     = 8'h00;

  // ---------------------------------------------------------------------------
  // Framing and timing
  // ---------------------------------------------------------------------------
  localparam int         SSM_BYTE_BITS      = 8;
  localparam logic [2:0] SSM_LAST_BIT       = 3'h7;
  localparam int         SSM_SCK_HALF       = 2;     // System clocks per half period of the clock.

  // ---------------------------------------------------------------------------
  // Master sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SSM_IDLE = 3'b001,
    SSM_LOW  = 3'b010,
    SSM_HIGH = 3'b100
  } ssm_fsm_e;

endpackage : ssm_pkg

`default_nettype wire

// ---- ssm_slave_link.sv ----
// Purpose: Slave shifter that runs on the serial clock from the far master.
// Assumes: Data is sampled on the rising edge and the clock idles low.
// Notes:   The clear input is asynchronous and loads constants only.
`default_nettype none

module ssm_slave_link
  import ssm_pkg::*;
(
  input  wire logic       sck_clk,
  input  wire logic       link_clear,
  input  wire logic       flag_clear,
  input  wire logic       mosi_bit,
  input  wire logic [7:0] tx_byte,
  output logic            miso_bit,
  output logic [7:0]      rx_byte,
  output logic            done_toggle
);

  typedef struct packed
  {
    logic [2:0] count;
    logic [7:0] shift;
  } ssm_link_s;

  typedef struct packed
  {
    logic [7:0] rx;
    logic       toggle;
  } ssm_flag_s;

  ssm_link_s  state_reg;
  ssm_link_s  state_next;
  ssm_flag_s  flag_reg;
  ssm_flag_s  flag_next;
  logic [7:0] source;

  // ---------------------------------------------------------------------------
  // Shift logic
  // ---------------------------------------------------------------------------
  // At a byte boundary the outgoing byte comes straight from the transmit
  // buffer, so no preload edge is needed before the first bit.
  always_comb
  begin
    state_next = state_reg;
    flag_next  = flag_reg;
    source     = (state_reg.count == 3'h0) ? tx_byte : state_reg.shift;
    state_next.shift = {source[6:0], mosi_bit};
    state_next.count = state_reg.count + 3'h1;
    if (state_reg.count == SSM_LAST_BIT)
    begin
      flag_next.rx     = {source[6:0], mosi_bit};
      flag_next.toggle = ~flag_reg.toggle;
    end
  end

  // While the clear is high no edge counts, which covers a deselected slave.
  always_ff @(posedge sck_clk or posedge link_clear)
  begin
    if (link_clear)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // The finished byte and its toggle survive a deselect, so a rising select never
  // flips the toggle; only leaving the slave role clears them.
  always_ff @(posedge sck_clk or posedge flag_clear)
  begin
    if (flag_clear)
    begin
      flag_reg <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  // Most significant bit of the live byte drives the return line.
  assign miso_bit    = (state_reg.count == 3'h0) ? tx_byte[7] : state_reg.shift[7];
  assign rx_byte     = flag_reg.rx;
  assign done_toggle = flag_reg.toggle;

endmodule : ssm_slave_link

`default_nettype wire

// ---- ssm_port.sv ----
// Purpose: SPI port acting as master or slave with three select pin modes.
// Assumes: REF_CLK at 20 MHz; the far master's clock is a second domain.
// Notes:   Clock phase and polarity are fixed: sample on rising, idle low.
`default_nettype none

module ssm_port
  import ssm_pkg::*;
#(
  parameter int SCK_HALF = SSM_SCK_HALF
)
(
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       CTRL_WRITE,
  input  wire logic       MASTER_ENABLE_IN,
  input  wire logic       PORT_ENABLE_IN,
  input  wire logic [1:0] SELECT_PIN_MODE_IN,
  input  wire logic       TX_WRITE,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       DONE_CLEAR,
  input  wire logic       FAULT_CLEAR,
  output logic            MASTER_ENABLE,
  output logic            PORT_ENABLE,
  output logic [1:0]      SELECT_PIN_MODE,
  output logic            TRANSFER_DONE,
  output logic            MODE_FAULT,
  output logic            BUSY,
  output logic [7:0]      RX_DATA,
  output logic            NSS_PIN_MAPPED,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE,
  input  wire logic       NSS_I,
  output logic            NSS_O,
  output logic            NSS_OE
);

  // ---------------------------------------------------------------------------
  // State of the system clock domain
  // ---------------------------------------------------------------------------
  typedef struct packed
  {
    logic       master_en;
    logic       port_en;
    logic [1:0] sel_mode;
    logic       done;
    logic       fault;
    logic [7:0] rx_data;
    logic [7:0] tx_buf;
    ssm_fsm_e   fsm;
    logic [3:0] div;
    logic [2:0] bits;
    logic [7:0] shift;
    logic       capture;
    logic       sck;
    logic       nss_s1;
    logic       nss_s2;
    logic       nss_prev;
    logic       miso_s1;
    logic       miso_s2;
    logic       tgl_s1;
    logic       tgl_s2;
    logic       tgl_seen;
    logic       link_idle;
    logic       link_gate;
  } ssm_state_s;

  ssm_state_s state_reg;
  ssm_state_s state_next;

  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF - 1);

  logic       is_master;
  logic       is_slave;
  logic       selected;
  logic       nss_fall;
  logic       slave_done;
  logic       master_done;
  logic       fault_hit;
  logic [7:0] master_byte;
  logic       link_clear;
  logic       link_miso;
  logic [7:0] link_rx;
  logic       link_toggle;

  // ---------------------------------------------------------------------------
  // Decoded roles
  // ---------------------------------------------------------------------------
  // Master or slave role follows the two enable bits.
  assign is_master = state_reg.port_en & state_reg.master_en;
  assign is_slave  = state_reg.port_en & ~state_reg.master_en;

  // A three-wire slave is always selected; otherwise a low select selects.
  assign selected = (state_reg.sel_mode == SSM_SEL_THREE_WIRE) | ~state_reg.nss_s2;

  // Edge detection reads the second synchroniser stage and its delayed copy.
  assign nss_fall = state_reg.nss_prev & ~state_reg.nss_s2;

  // A new toggle from the link domain marks a finished slave byte.
  assign slave_done = (state_reg.tgl_s2 ^ state_reg.tgl_seen) & is_slave;

  // Only the multi-master setting lets the select pin knock out the master.
  assign fault_hit = is_master & (state_reg.sel_mode == SSM_SEL_MULTI) & nss_fall;

  // Byte assembled by the master at its last bit.
  assign master_byte = {state_reg.shift[6:0], state_reg.capture};
  assign master_done = (state_reg.fsm == SSM_HIGH) & (state_reg.div == HALF_LAST)
                     & (state_reg.bits == SSM_LAST_BIT);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // Synchronisers: first stages feed only the second stages.
    state_next.nss_s1   = NSS_I;
    state_next.nss_s2   = state_reg.nss_s1;
    state_next.nss_prev = state_reg.nss_s2;
    state_next.miso_s1  = MISO_I;
    state_next.miso_s2  = state_reg.miso_s1;
    state_next.tgl_s1   = link_toggle;
    state_next.tgl_s2   = state_reg.tgl_s1;
    state_next.tgl_seen = state_reg.tgl_s2;

    // Software writes to the control bits.
    if (CTRL_WRITE)
    begin
      state_next.master_en = MASTER_ENABLE_IN;
      state_next.port_en   = PORT_ENABLE_IN;
      state_next.sel_mode  = SELECT_PIN_MODE_IN;
    end

    // A mode fault overrides a same-cycle write so the bus is freed at once.
    if (fault_hit)
    begin
      state_next.master_en = 1'b0;
      state_next.port_en   = 1'b0;
    end

    // Sticky flags: a set in the cycle of a clear is kept.
    state_next.fault = fault_hit | (state_reg.fault & ~FAULT_CLEAR);
    state_next.done  = master_done | slave_done | (state_reg.done & ~DONE_CLEAR);

    // Received byte from whichever role finished.
    if (master_done)
    begin
      state_next.rx_data = master_byte;
    end
    else if (slave_done)
    begin
      state_next.rx_data = link_rx;
    end

    // The slave transmit buffer takes any write outside a master transfer.
    if (TX_WRITE & (state_reg.fsm == SSM_IDLE))
    begin
      state_next.tx_buf = TX_DATA;
    end

    // Master sequencer; the clock stays low whenever it is idle.
    unique case (state_reg.fsm)
      SSM_IDLE:
      begin
        state_next.sck  = 1'b0;
        state_next.div  = 4'h0;
        state_next.bits = 3'h0;
        if (TX_WRITE & is_master & ~fault_hit)
        begin
          state_next.shift = TX_DATA;
          state_next.fsm   = SSM_LOW;
        end
      end
      SSM_LOW:
      begin
        if (state_reg.div == HALF_LAST)
        begin
          state_next.div     = 4'h0;
          state_next.sck     = 1'b1;
          state_next.capture = state_reg.miso_s2;
          state_next.fsm     = SSM_HIGH;
        end
        else
        begin
          state_next.div = state_reg.div + 4'h1;
        end
      end
      SSM_HIGH:
      begin
        if (state_reg.div == HALF_LAST)
        begin
          state_next.div   = 4'h0;
          state_next.sck   = 1'b0;
          state_next.shift = master_byte;
          if (state_reg.bits == SSM_LAST_BIT)
          begin
            state_next.fsm = SSM_IDLE;
          end
          else
          begin
            state_next.bits = state_reg.bits + 3'h1;
            state_next.fsm  = SSM_LOW;
          end
        end
        else
        begin
          state_next.div = state_reg.div + 4'h1;
        end
      end
      default:
      begin
        state_next.fsm = SSM_IDLE;
      end
    endcase

    // Losing the master role mid-byte aborts the byte and parks the clock.
    if (~is_master | fault_hit)
    begin
      state_next.fsm = SSM_IDLE;
      state_next.sck = 1'b0;
    end

    // Registered hold terms for the link domain keep its clear glitch free.
    state_next.link_idle = ~(state_next.port_en & ~state_next.master_en);
    state_next.link_gate = (state_next.sel_mode != SSM_SEL_THREE_WIRE);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      state_reg           <= '0;
      state_reg.master_en <= SSM_MASTER_RESET;
      state_reg.port_en   <= SSM_ENABLE_RESET;
      state_reg.sel_mode  <= SSM_SEL_RESET;
      state_reg.rx_data   <= SSM_BYTE_RESET;
      state_reg.tx_buf    <= SSM_BYTE_RESET;
      state_reg.fsm       <= SSM_IDLE;
      state_reg.nss_s1    <= 1'b1;
      state_reg.nss_s2    <= 1'b1;
      state_reg.nss_prev  <= 1'b1;
      state_reg.link_idle <= 1'b1;
      state_reg.link_gate <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Link clock domain
  // ---------------------------------------------------------------------------
  // The slave counter is held clear while the port is not a slave, and while a
  // four-wire slave is deselected; so a falling select always starts at bit 0.
  // A three-wire slave has no such reset and recovers only by a disable.
  // The finished byte and its toggle are cleared only when the slave role is
  // left. Clearing them on a deselect would flip the toggle back and hand the
  // system side a second, false end of byte every time the select pin rises.
  // The price is that a false end of byte can be reported if the role is left and taken up
  // again within two system clocks, which software has no reason to do.
  assign link_clear = state_reg.link_idle | (state_reg.link_gate & NSS_I);

  ssm_slave_link u_link
  (
    .sck_clk     (SCK_I),
    .link_clear  (link_clear),
    .flag_clear  (state_reg.link_idle),
    .mosi_bit    (MOSI_I),
    .tx_byte     (state_reg.tx_buf),
    .miso_bit    (link_miso),
    .rx_byte     (link_rx),
    .done_toggle (link_toggle)
  );

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // Data out and clock are driven only by the master.
  assign MOSI_OE = is_master;
  assign MOSI_O  = state_reg.shift[7];
  assign SCK_OE  = is_master;
  assign SCK_O   = state_reg.sck;

  // Return line is driven only by an enabled, selected slave.
  assign MISO_OE = is_slave & selected;
  assign MISO_O  = link_miso;

  // The select pin is an output whenever the high mode bit is set.
  assign NSS_OE  = state_reg.sel_mode[SSM_SEL_HIGH_POS];
  assign NSS_O   = state_reg.sel_mode[SSM_SEL_LOW_POS];

  // Pin mapping depends on the mode alone, not on the role.
  assign NSS_PIN_MAPPED = (state_reg.sel_mode != SSM_SEL_THREE_WIRE);

  // ---------------------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------------------
  assign MASTER_ENABLE   = state_reg.master_en;
  assign PORT_ENABLE     = state_reg.port_en;
  assign SELECT_PIN_MODE = state_reg.sel_mode;
  assign TRANSFER_DONE   = state_reg.done;
  assign MODE_FAULT      = state_reg.fault;
  assign BUSY            = (state_reg.fsm != SSM_IDLE);
  assign RX_DATA         = state_reg.rx_data;

endmodule : ssm_port

`default_nettype wire

// ---- ssm_port_chk.sv ----
// Purpose: Pin-level checks on the SPI port with select pin modes.
// Assumes: Only the top ports are visible; one clock domain here.
// Notes:   Bound into every instance of the port.
`default_nettype none

module ssm_port_chk
  import ssm_pkg::*;
#(
  parameter int SCK_HALF = SSM_SCK_HALF
)
(
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  input wire logic       TX_WRITE,
  input wire logic [7:0] TX_DATA,
  input wire logic       MASTER_ENABLE,
  input wire logic       PORT_ENABLE,
  input wire logic [1:0] SELECT_PIN_MODE,
  input wire logic       TRANSFER_DONE,
  input wire logic       MODE_FAULT,
  input wire logic       BUSY,
  input wire logic       NSS_PIN_MAPPED,
  input wire logic       MOSI_O,
  input wire logic       MOSI_OE,
  input wire logic       MISO_OE,
  input wire logic       SCK_O,
  input wire logic       SCK_OE,
  input wire logic       NSS_I,
  input wire logic       NSS_O,
  input wire logic       NSS_OE
);
  timeunit 1ns;
  timeprecision 100ps;

  // Start of a master byte to its done flag, in system clocks.
  localparam int DONE_LAT = 1 + 2 * SSM_BYTE_BITS * SCK_HALF;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  a_master_drives: assert property (MASTER_ENABLE && PORT_ENABLE |-> MOSI_OE && SCK_OE)
    else $error("master does not drive data and clock");
  a_slave_listens: assert property (!MASTER_ENABLE |-> !MOSI_OE && !SCK_OE)
    else $error("slave drives data out or clock");
  a_miso_quiet: assert property (!PORT_ENABLE || MASTER_ENABLE |-> !MISO_OE)
    else $error("return line driven while disabled or master");
  a_sck_idle: assert property (!BUSY |-> !SCK_O)
    else $error("clock away from idle level");
  a_sck_half: assert property ($rose(SCK_O) |-> ##SCK_HALF !SCK_O)
    else $error("clock high phase has wrong length");
  a_first_bit: assert property ($rose(BUSY) |-> MOSI_O == $past(TX_DATA[7]))
    else $error("first bit is not the top bit");
  a_mosi_on_fall: assert property (BUSY && $past(BUSY) && $changed(MOSI_O) |-> $fell(SCK_O))
    else $error("data out moved away from a clock fall");
  a_done_time: assert property (TX_WRITE && MASTER_ENABLE && PORT_ENABLE && !BUSY |-> ##DONE_LAT TRANSFER_DONE)
    else $error("master byte done at wrong time");
  a_fault_off: assert property (MASTER_ENABLE && PORT_ENABLE && $fell(NSS_I)
    && SELECT_PIN_MODE == SSM_SEL_MULTI |-> ##[1:5] (MODE_FAULT && !MASTER_ENABLE && !PORT_ENABLE))
    else $error("select fall did not stop the master");
  a_nss_out: assert property (NSS_OE == SELECT_PIN_MODE[1] && (!NSS_OE || NSS_O == SELECT_PIN_MODE[0]))
    else $error("select output wrong for mode");
  a_nss_mapped: assert property (NSS_PIN_MAPPED == (SELECT_PIN_MODE != 2'h0))
    else $error("select pin mapping wrong");
endmodule : ssm_port_chk

bind ssm_port ssm_port_chk #(.SCK_HALF(SCK_HALF)) u_ssm_port_chk
(
  .REF_CLK(REF_CLK), .RST_B(RST_B), .TX_WRITE(TX_WRITE), .TX_DATA(TX_DATA),
  .MASTER_ENABLE(MASTER_ENABLE), .PORT_ENABLE(PORT_ENABLE), .SELECT_PIN_MODE(SELECT_PIN_MODE),
  .TRANSFER_DONE(TRANSFER_DONE), .MODE_FAULT(MODE_FAULT), .BUSY(BUSY), .NSS_PIN_MAPPED(NSS_PIN_MAPPED),
  .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
  .NSS_I(NSS_I), .NSS_O(NSS_O), .NSS_OE(NSS_OE)
);

`default_nettype wire

// ---- ssm_far_slave.sv ----
// Purpose: Behavioural far slave answering the port when it is master.
// Assumes: Sample on rising clock, shift on falling, clock idles low.
// Notes:   When not selected it shows the inverse of its top bit.
`default_nettype none

module ssm_far_slave
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sh = 8'h00;

  // Shift register: loaded by the bench, moved on each falling clock.
  always @(posedge load or negedge sck)
    if (load)
      sh <= load_byte;
    else
      sh <= {sh[6:0], 1'b0};
  always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};

  // Sole slave on the line, so it never has to share the return line.
  assign miso = !sel_n ? sh[7] : ~sh[7];
endmodule : ssm_far_slave

`default_nettype wire

// ---- tb_ssm_port.sv ----
// Purpose: Self-checking bench for the SPI port with select pin modes.
// Assumes: 50 ns system clock, 15 ns far master clock inside frames.
// Notes:   Half period of 3 system clocks, longer than the default of 2, slows master bytes.
`default_nettype none

module tb_ssm_port;
  timeunit 1ns;
  timeprecision 100ps;
  import ssm_pkg::*;

  localparam int HALF = 3;
  logic REF_CLK = 0, RST_B = 0, CTRL_WRITE = 0, MASTER_ENABLE_IN = 0, PORT_ENABLE_IN = 0;
  logic [1:0] SELECT_PIN_MODE_IN = 2'h1;
  logic TX_WRITE = 0, DONE_CLEAR = 0, FAULT_CLEAR = 0, tb_mosi = 0, tb_sck = 0, tb_nss = 1, fs_load = 0;
  logic [7:0] TX_DATA = 8'h00, fs_byte = 8'h00, got, fs_rx, RX_DATA;
  logic [1:0] SELECT_PIN_MODE;
  logic MASTER_ENABLE, PORT_ENABLE, TRANSFER_DONE, MODE_FAULT, BUSY, NSS_PIN_MAPPED, fs_miso;
  logic MOSI_O, MOSI_OE, MISO_O, MISO_OE, SCK_O, SCK_OE, NSS_O, NSS_OE;
  int n_mismatch = 0, checked = 0;

  // Each line's level comes from whoever has its enable up.
  wire logic mosi_w = MOSI_OE ? MOSI_O : tb_mosi;
  wire logic miso_w = MISO_OE ? MISO_O : fs_miso;
  wire logic sck_w = SCK_OE ? SCK_O : tb_sck;
  wire logic nss_w = NSS_OE ? NSS_O : tb_nss;

  // System clock.
  always #25 REF_CLK = ~REF_CLK;

  ssm_port #(.SCK_HALF(HALF)) u_ssm_port
  (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .CTRL_WRITE(CTRL_WRITE), .MASTER_ENABLE_IN(MASTER_ENABLE_IN),
    .PORT_ENABLE_IN(PORT_ENABLE_IN), .SELECT_PIN_MODE_IN(SELECT_PIN_MODE_IN), .TX_WRITE(TX_WRITE),
    .TX_DATA(TX_DATA), .DONE_CLEAR(DONE_CLEAR), .FAULT_CLEAR(FAULT_CLEAR), .MASTER_ENABLE(MASTER_ENABLE),
    .PORT_ENABLE(PORT_ENABLE), .SELECT_PIN_MODE(SELECT_PIN_MODE), .TRANSFER_DONE(TRANSFER_DONE),
    .MODE_FAULT(MODE_FAULT), .BUSY(BUSY), .RX_DATA(RX_DATA), .NSS_PIN_MAPPED(NSS_PIN_MAPPED),
    .MOSI_I(mosi_w), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_I(miso_w), .MISO_O(MISO_O),
    .MISO_OE(MISO_OE), .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .NSS_I(nss_w), .NSS_O(NSS_O),
    .NSS_OE(NSS_OE)
  );

  ssm_far_slave u_ssm_far_slave
  (
    .sck(sck_w), .mosi(mosi_w), .sel_n(1'b0), .load(fs_load), .load_byte(fs_byte),
    .miso(fs_miso), .rx_byte(fs_rx)
  );

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK);
    #2;
  endtask : step

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Control write; also clears the done flag so each test starts clean.
  task automatic ctrl(input logic me, input logic pe, input logic [1:0] md);
    {CTRL_WRITE, DONE_CLEAR, MASTER_ENABLE_IN, PORT_ENABLE_IN, SELECT_PIN_MODE_IN} = {2'b11, me, pe, md};
    step(1);
    {CTRL_WRITE, DONE_CLEAR} = 2'b00;
    step(1);
  endtask : ctrl

  // Master byte; a second write mid-byte must be ignored.
  task automatic mbyte(input logic [7:0] tx, input logic [7:0] far);
    int n;
    {fs_load, fs_byte, TX_WRITE, TX_DATA} = {1'b1, far, 1'b1, tx};
    step(1);
    {fs_load, TX_WRITE} = 2'b00;
    step(3);
    {TX_WRITE, TX_DATA} = {1'b1, ~tx};
    step(1);
    TX_WRITE = 0;
    n = 0;
    while (BUSY === 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    chk(RX_DATA, far);
    chk(fs_rx, tx);
    chk({7'h0, TRANSFER_DONE}, 8'h01);
  endtask : mbyte

  // Far master clocking n bits; the clock stands still outside the frame.
  task automatic sbyte(input logic [7:0] tx, input int nb);
    for (int i = 7; i > 7 - nb; i--)
    begin
      tb_mosi = tx[i];
      #7.5;
      got[i] = miso_w;
      tb_sck = 1;
      #7.5;
      tb_sck = 0;
    end
    tb_mosi = ~tb_mosi;
    step(6);
  endtask : sbyte

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // Watchdog: the whole run needs well under 20000 system clocks.
  initial
  begin
    #(20000 * 50);
    n_mismatch++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    step(20);
    RST_B = 1;
    step(1);
    chk({MASTER_ENABLE, PORT_ENABLE, SELECT_PIN_MODE, NSS_PIN_MAPPED, MISO_OE, MOSI_OE, SCK_OE}, 8'h18);
    chk(RX_DATA, 8'h00);
    for (int m = 0; m < 4; m++)
      if (m != 1)
      begin
        ctrl(1, 1, m[1:0]);
        chk({6'h0, NSS_OE, NSS_PIN_MAPPED}, {6'h0, m[1], m != 0});
        if (m[1])
          chk({7'h0, NSS_O}, {7'h0, m[0]});
        mbyte(8'h3c ^ m[7:0], 8'ha5 ^ m[7:0]);
      end
    ctrl(1, 1, 2'h1);
    step(3);
    tb_nss = 0;
    step(6);
    chk({5'h0, MODE_FAULT, MASTER_ENABLE, PORT_ENABLE}, 8'h04);
    FAULT_CLEAR = 1;
    step(1);
    {FAULT_CLEAR, tb_nss} = 2'b01;
    step(1);
    chk({7'h0, MODE_FAULT}, 8'h00);
    ctrl(0, 1, 2'h1);
    chk({7'h0, MISO_OE}, 8'h00);
    sbyte(8'hff, 8);
    chk({7'h0, TRANSFER_DONE}, 8'h00);
    tb_nss = 0;
    step(3);
    {TX_WRITE, TX_DATA} = {1'b1, 8'h96};
    step(1);
    TX_WRITE = 0;
    chk({7'h0, MISO_OE}, 8'h01);
    sbyte(8'h00, 3);
    tb_nss = 1;
    step(4);
    tb_nss = 0;
    step(3);
    sbyte(8'h5a, 8);
    chk(RX_DATA, 8'h5a);
    chk(got, 8'h96);
    chk({7'h0, TRANSFER_DONE}, 8'h01);
    // Deselecting after a whole byte must not report a second byte.
    {DONE_CLEAR, tb_nss} = 2'b11;
    step(1);
    DONE_CLEAR = 0;
    step(6);
    chk({7'h0, TRANSFER_DONE}, 8'h00);
    chk(RX_DATA, 8'h5a);
    ctrl(0, 1, 2'h0);
    tb_nss = 1;
    step(2);
    chk({6'h0, MISO_OE, MISO_O}, 8'h03);
    sbyte(8'hc3, 8);
    chk(RX_DATA, 8'hc3);
    chk(got, 8'h96);
    ctrl(0, 0, 2'h1);
    chk({7'h0, MISO_OE}, 8'h00);
    complete_run();
  end
endmodule : tb_ssm_port

`default_nettype wire
